/* design/scratch_pkg.sv */
/*
 * constants, crc helper and state type for the scratchpad command slave.
 * assumes nothing; used by name only, never imported.
 */
package scratch_pkg;
    localparam logic [7:0] CMD_ERASE = 8'hc3;
    localparam logic [7:0] CMD_READ = 8'haa;
    localparam logic [7:0] CMD_WRITE = 8'h0f;
    localparam logic [7:0] FILL_BYTE = 8'hff;
    localparam logic [15:0] ADDR_MAX = 16'h01ff;
    localparam int PAD_BYTES = 32;
    localparam logic [4:0] OFS_LAST = 5'h1f;
    localparam int HDR_BYTES = 3;
    localparam int ES_PF_BIT = 7;
    localparam logic [15:0] CRC_POLY_R = 16'ha001;
    localparam logic [15:0] CRC_INIT = 16'h0000;
    localparam int CRC_BITS = 16;
    localparam int CLK_NS = 50;
    localparam int ERASE_NS = 32000;
    // least time: round up
    localparam int ERASE_CYC = (ERASE_NS + CLK_NS - 1) / CLK_NS;
    localparam int FIFO_DEPTH = 8;
    // arbitrary neutral family code
    localparam logic [7:0] FAMILY_DEF = 8'h5a;

    typedef enum logic [2:0] {S_CMD, S_ADDR, S_WDATA, S_READ, S_FILL, S_DONE, S_IDLE} state_e;

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++)
        begin
            r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC_POLY_R) : (r >> 1);
        end
        return r;
    endfunction
endpackage

/* design/scratchpad_command_slave.sv */
/*
 * scratchpad command slave: erase, read and write of a 32-byte scratchpad
 * behind a single-wire bus, plus the byte fifo in the write data path.
 * assumes a bus front end on MCLK that delivers master write bits, read
 * slot strobes and a pulse per bus reset; slot timing lives there.
 */
//
// Contract
// - the erase code clears the concealment flag and is followed by a two-byte address and no data.
// - erase fills every scratchpad byte with ones whatever address was given.
// - during the erase fill, lasting about 32 us, every read slot returns one.
// - after the fill the device returns alternating zeros and ones, and the master reads at least eight.
// - the completion pattern gathered into bytes reads as 0xaa.
// - read returns both address bytes, the ending offset and status byte, then data from the start offset.
// - after the last scratchpad byte read returns the inverted crc and then ones.
// - write needs concealment clear and an address up to 01ff, then address and data follow the code.
// - write data is stored from the start offset and the last offset written becomes the end offset.
// - only whole bytes are kept; a cut final byte is dropped and sets the partial-byte flag.
// - write crc16 starts cleared and takes the code, both address bytes and every data byte.
// - the master may stop a write at any time, and with end offset 31 sixteen read slots return the crc.
// - identification begins with an 8-bit family code byte.
`timescale 1ns/1ps
`default_nettype none

module byte_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 8
) (
    input wire logic clk,                 // clock
    input wire logic rst,                 // async reset
    input wire logic in_valid,            // push request
    output logic in_ready,                // not full
    input wire logic [WIDTH-1:0] in_data, // pushed word
    output logic out_valid,               // not empty
    input wire logic out_ready,           // pop request
    output logic [WIDTH-1:0] out_data     // head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rp_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wp_q] <= in_data;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
            if (pop)
                rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////

module scratchpad_command_slave #(
    parameter int ERASE_CYC = scratch_pkg::ERASE_CYC,
    parameter logic [7:0] FAMILY = scratch_pkg::FAMILY_DEF
) (
    input wire logic MCLK,               // 20 mhz clock
    input wire logic RESET,              // async reset, high
    input wire logic BUS_RESET,          // pulse: bus reset, new command
    input wire logic RX_VALID,           // master write slot bit valid
    input wire logic RX_BIT,             // master write slot bit, lsb first
    output logic RX_READY,               // low stalls write bits
    input wire logic RD_SLOT,            // pulse: master read slot
    output logic TX_BIT,                 // read slot answer
    input wire logic MEM_HOLD,           // stalls fifo writes to the scratchpad
    input wire logic SET_CONCEAL,        // pulse: set concealment
    output logic CONCEALED,              // concealment flag
    output logic PARTIAL,                // partial-byte flag
    output logic [4:0] END_OFFSET,       // ending byte offset
    output logic [7:0] FAMILY_CODE       // family code byte
);
    scratch_pkg::state_e st_q;
    logic [7:0] mem [scratch_pkg::PAD_BYTES];
    logic [7:0] rx_sr_q, cmd_q;
    logic [2:0] rx_cnt_q, tx_cnt_q;
    logic addr_hi_q, wfull_q, alt_q, conceal_q, pf_q;
    logic [15:0] ta_q, crc_q;
    logic [4:0] wofs_q, end_q;
    logic [5:0] rd_idx_q;
    logic [4:0] wcrc_q;
    logic [15:0] fill_cnt_q;
    logic [7:0] fam_q;
    logic bit_take, byte_take, rd_data_slot;
    logic [7:0] byte_val, rd_byte;
    logic [5:0] ndata, crc_idx;
    logic fin_rdy, fout_val, fout_rdy;
    logic [12:0] fout;

    assign bit_take = RX_VALID && RX_READY;
    assign byte_take = bit_take && (rx_cnt_q == 3'h7);
    assign byte_val = {RX_BIT, rx_sr_q[7:1]};
    assign RX_READY = (st_q == scratch_pkg::S_WDATA) ? fin_rdy : 1'b1;
    assign ndata = 6'(scratch_pkg::PAD_BYTES) - {1'b0, ta_q[4:0]};
    assign crc_idx = 6'(scratch_pkg::HDR_BYTES) + ndata;
    assign rd_data_slot = RD_SLOT && (tx_cnt_q == 3'h7) && (rd_idx_q < crc_idx);
    assign CONCEALED = conceal_q;
    assign PARTIAL = pf_q;
    assign END_OFFSET = end_q;
    assign FAMILY_CODE = fam_q;

    // read stream byte select
    always_comb
    begin
        rd_byte = 8'hff;
        if (rd_idx_q == 6'h0)
            rd_byte = ta_q[7:0];
        else if (rd_idx_q == 6'h1)
            rd_byte = ta_q[15:8];
        else if (rd_idx_q == 6'h2)
            rd_byte = {pf_q, 2'h0, end_q};
        else if (rd_idx_q < crc_idx)
            rd_byte = mem[5'(ta_q[4:0] + 5'(rd_idx_q - 6'(scratch_pkg::HDR_BYTES)))];
        else if (rd_idx_q == crc_idx)
            rd_byte = ~crc_q[7:0];
        else if (rd_idx_q == crc_idx + 6'h1)
            rd_byte = ~crc_q[15:8];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // command sequencing

    always_ff @(posedge MCLK or posedge RESET)
    begin
        if (RESET)
        begin
            st_q <= scratch_pkg::S_IDLE;
            cmd_q <= 8'h00;
            addr_hi_q <= 1'b0;
            ta_q <= 16'h0000;
            fill_cnt_q <= 16'h0000;
        end
        else if (BUS_RESET)
        begin
            st_q <= scratch_pkg::S_CMD;
            addr_hi_q <= 1'b0;
        end
        else
        begin
            unique case (st_q)
                scratch_pkg::S_CMD:
                    if (byte_take)
                    begin
                        cmd_q <= byte_val;
                        if (byte_val == scratch_pkg::CMD_ERASE || byte_val == scratch_pkg::CMD_WRITE)
                            st_q <= scratch_pkg::S_ADDR;
                        else if (byte_val == scratch_pkg::CMD_READ && !conceal_q)
                            st_q <= scratch_pkg::S_READ;
                        else
                            st_q <= scratch_pkg::S_IDLE;
                    end
                scratch_pkg::S_ADDR:
                    if (byte_take)
                    begin
                        addr_hi_q <= 1'b1;
                        if (!addr_hi_q && cmd_q == scratch_pkg::CMD_WRITE)
                            ta_q[7:0] <= byte_val;
                        if (addr_hi_q && cmd_q == scratch_pkg::CMD_ERASE)
                        begin
                            st_q <= scratch_pkg::S_FILL;
                            fill_cnt_q <= 16'h0000;
                        end
                        else if (addr_hi_q)
                        begin
                            ta_q[15:8] <= byte_val;
                            if (!conceal_q && {byte_val, ta_q[7:0]} <= scratch_pkg::ADDR_MAX)
                                st_q <= scratch_pkg::S_WDATA;
                            else
                                st_q <= scratch_pkg::S_IDLE;
                        end
                    end
                scratch_pkg::S_FILL:
                    if (fill_cnt_q == 16'(ERASE_CYC - 1))
                        st_q <= scratch_pkg::S_DONE;
                    else
                        fill_cnt_q <= fill_cnt_q + 16'h1;
                scratch_pkg::S_WDATA, scratch_pkg::S_READ, scratch_pkg::S_DONE, scratch_pkg::S_IDLE:
                    st_q <= st_q;
            endcase
        end
    end

    always_ff @(posedge MCLK or posedge RESET)
    begin
        if (RESET)
        begin
            rx_sr_q <= 8'h00;
            rx_cnt_q <= 3'h0;
        end
        else if (BUS_RESET)
            rx_cnt_q <= 3'h0;
        else if (bit_take)
        begin
            rx_sr_q <= byte_val;
            rx_cnt_q <= rx_cnt_q + 3'h1;
        end
    end

    // concealment: erase clearing wins over a same-cycle set
    always_ff @(posedge MCLK or posedge RESET)
    begin
        if (RESET)
            conceal_q <= 1'b0;
        else if (st_q == scratch_pkg::S_CMD && byte_take && byte_val == scratch_pkg::CMD_ERASE && !BUS_RESET)
            conceal_q <= 1'b0;
        else if (SET_CONCEAL)
            conceal_q <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // write offsets, partial flag, crc

    always_ff @(posedge MCLK or posedge RESET)
    begin
        if (RESET)
        begin
            wofs_q <= 5'h00;
            wfull_q <= 1'b0;
            end_q <= 5'h00;
            pf_q <= 1'b0;
        end
        else if (BUS_RESET)
        begin
            if (st_q == scratch_pkg::S_WDATA && rx_cnt_q != 3'h0)
                pf_q <= 1'b1;
        end
        else if (st_q == scratch_pkg::S_ADDR && byte_take && addr_hi_q && cmd_q == scratch_pkg::CMD_WRITE)
        begin
            wofs_q <= ta_q[4:0];
            wfull_q <= 1'b0;
            pf_q <= 1'b0;
        end
        else if (st_q == scratch_pkg::S_WDATA && byte_take && !wfull_q)
        begin
            end_q <= wofs_q;
            if (wofs_q == scratch_pkg::OFS_LAST)
                wfull_q <= 1'b1;
            else
                wofs_q <= wofs_q + 5'h1;
        end
    end

    always_ff @(posedge MCLK or posedge RESET)
    begin
        if (RESET)
            crc_q <= scratch_pkg::CRC_INIT;
        else if (BUS_RESET)
            crc_q <= crc_q;
        else if (st_q == scratch_pkg::S_CMD && byte_take)
            crc_q <= scratch_pkg::crc_byte(scratch_pkg::CRC_INIT, byte_val);
        else if ((st_q == scratch_pkg::S_ADDR || st_q == scratch_pkg::S_WDATA) && byte_take)
            crc_q <= scratch_pkg::crc_byte(crc_q, byte_val);
        else if (st_q == scratch_pkg::S_READ && rd_data_slot)
            crc_q <= scratch_pkg::crc_byte(crc_q, rd_byte);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // scratchpad storage; fill has priority, the fifo waits

    byte_fifo #(
        .WIDTH(13),
        .DEPTH(scratch_pkg::FIFO_DEPTH)
    ) u_wfifo (
        .clk(MCLK),
        .rst(RESET),
        .in_valid(st_q == scratch_pkg::S_WDATA && byte_take && !wfull_q && !BUS_RESET),
        .in_ready(fin_rdy),
        .in_data({wofs_q, byte_val}),
        .out_valid(fout_val),
        .out_ready(fout_rdy),
        .out_data(fout)
    );
    assign fout_rdy = !MEM_HOLD && (st_q != scratch_pkg::S_FILL);

    always_ff @(posedge MCLK)
    begin
        if (st_q == scratch_pkg::S_FILL && fill_cnt_q < 16'(scratch_pkg::PAD_BYTES))
            mem[fill_cnt_q[4:0]] <= scratch_pkg::FILL_BYTE;
        else if (fout_val && fout_rdy)
            mem[fout[12:8]] <= fout[7:0];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read slot answers

    always_ff @(posedge MCLK or posedge RESET)
    begin
        if (RESET)
        begin
            TX_BIT <= 1'b1;
            tx_cnt_q <= 3'h0;
            rd_idx_q <= 6'h00;
            wcrc_q <= 5'h00;
            alt_q <= 1'b0;
        end
        else if (BUS_RESET)
        begin
            tx_cnt_q <= 3'h0;
            rd_idx_q <= 6'h00;
            wcrc_q <= 5'h00;
            alt_q <= 1'b0;
        end
        else if (RD_SLOT)
        begin
            unique case (st_q)
                scratch_pkg::S_DONE:
                begin
                    TX_BIT <= alt_q;
                    alt_q <= !alt_q;
                end
                scratch_pkg::S_READ:
                begin
                    TX_BIT <= rd_byte[tx_cnt_q];
                    tx_cnt_q <= tx_cnt_q + 3'h1;
                    if (tx_cnt_q == 3'h7 && rd_idx_q != 6'h3f)
                        rd_idx_q <= rd_idx_q + 6'h1;
                end
                scratch_pkg::S_WDATA:
                begin
                    if (end_q == scratch_pkg::OFS_LAST && wcrc_q < 5'(scratch_pkg::CRC_BITS))
                    begin
                        TX_BIT <= crc_q[wcrc_q[3:0]];
                        wcrc_q <= wcrc_q + 5'h1;
                    end
                    else
                        TX_BIT <= 1'b1;
                end
                scratch_pkg::S_CMD, scratch_pkg::S_ADDR, scratch_pkg::S_FILL, scratch_pkg::S_IDLE:
                    TX_BIT <= 1'b1;
            endcase
        end
    end

    always_ff @(posedge MCLK or posedge RESET)
    begin
        if (RESET)
            fam_q <= 8'h00;
        else
            fam_q <= FAMILY;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    a_erase_clears_flag: assert property (@(posedge MCLK) disable iff (RESET)
        (st_q == scratch_pkg::S_CMD && byte_take && byte_val == scratch_pkg::CMD_ERASE && !BUS_RESET)
        |=> !conceal_q ##0 st_q == scratch_pkg::S_ADDR)
        else $error("erase did not clear concealment");

    a_fill_reads_ones: assert property (@(posedge MCLK) disable iff (RESET)
        (st_q == scratch_pkg::S_FILL && RD_SLOT && !BUS_RESET) |=> TX_BIT)
        else $error("read slot during fill not one");

    a_fill_length: assert property (@(posedge MCLK) disable iff (RESET)
        $fell(st_q == scratch_pkg::S_FILL) && !$past(BUS_RESET) |-> $past(fill_cnt_q) == 16'(ERASE_CYC - 1))
        else $error("fill length wrong");

    a_done_alternates: assert property (@(posedge MCLK) disable iff (RESET)
        (st_q == scratch_pkg::S_DONE && RD_SLOT && !BUS_RESET) ##1
        (st_q == scratch_pkg::S_DONE && RD_SLOT && !BUS_RESET) |=> TX_BIT != $past(TX_BIT))
        else $error("completion bits do not alternate");

    a_done_first_zero: assert property (@(posedge MCLK) disable iff (RESET)
        (st_q == scratch_pkg::S_DONE && RD_SLOT && !BUS_RESET && !alt_q) |=> !TX_BIT)
        else $error("completion byte phase wrong");

    a_write_gate: assert property (@(posedge MCLK) disable iff (RESET)
        (st_q == scratch_pkg::S_ADDR && byte_take && addr_hi_q && cmd_q == scratch_pkg::CMD_WRITE
         && !BUS_RESET && conceal_q) |=> st_q == scratch_pkg::S_IDLE)
        else $error("write accepted while concealed");

    a_end_tracks: assert property (@(posedge MCLK) disable iff (RESET)
        (st_q == scratch_pkg::S_WDATA && byte_take && !wfull_q && !BUS_RESET) |=> END_OFFSET == $past(wofs_q))
        else $error("end offset not updated");

    a_partial_cut: assert property (@(posedge MCLK) disable iff (RESET)
        (BUS_RESET && st_q == scratch_pkg::S_WDATA && rx_cnt_q != 3'h0) |=> PARTIAL ##1 PARTIAL || BUS_RESET)
        else $error("partial byte not flagged");

    a_write_crc_out: assert property (@(posedge MCLK) disable iff (RESET)
        (st_q == scratch_pkg::S_WDATA && RD_SLOT && !BUS_RESET && end_q == scratch_pkg::OFS_LAST && wcrc_q < 5'h10)
        |=> TX_BIT == $past(crc_q[wcrc_q[3:0]]))
        else $error("write crc bit wrong");

    a_read_header: assert property (@(posedge MCLK) disable iff (RESET)
        (st_q == scratch_pkg::S_READ && RD_SLOT && !BUS_RESET && rd_idx_q == 6'h0) |=> TX_BIT == $past(ta_q[tx_cnt_q]))
        else $error("address byte not sent first");

    a_tail_ones: assert property (@(posedge MCLK) disable iff (RESET)
        (st_q == scratch_pkg::S_READ && RD_SLOT && !BUS_RESET && rd_idx_q > crc_idx + 6'h1) |=> TX_BIT)
        else $error("bits after crc not one");

    // a bit offered while the fifo is full must not advance the bit counter
    a_rx_stall: assert property (@(posedge MCLK) disable iff (RESET)
        (st_q == scratch_pkg::S_WDATA && RX_VALID && !fin_rdy && !BUS_RESET) |=> rx_cnt_q == $past(rx_cnt_q))
        else $error("bit taken while fifo full");

    a_family: assert property (@(posedge MCLK) disable iff (RESET)
        !$past(RESET) |-> FAMILY_CODE == FAMILY)
        else $error("family code wrong");
endmodule

`default_nettype wire

/* testbench/bus_master_model.sv */
/*
 * behavioural single-wire bus master: bus reset, write bits, read slots.
 * assumes the slave samples on the rising edge of clk; every request is
 * changed 1 ns after a rising edge and held until the edge that takes it.
 */
`timescale 1ns/1ps
`default_nettype none

module bus_master_model (
    input wire logic clk,       // bus clock
    output logic bus_reset,     // one-cycle bus reset pulse
    output logic rx_valid,      // write bit valid
    output logic rx_bit,        // write bit, lsb first
    input wire logic rx_ready,  // slave accepts bits
    output logic rd_slot,       // read slot strobe
    input wire logic tx_bit,    // slave answer bit
    output logic hang           // a wait ran out of its bound
);
    initial
    begin
        bus_reset = 1'b0;
        rx_valid = 1'b0;
        rx_bit = 1'b0;
        rd_slot = 1'b0;
        hang = 1'b0;
    end

    task automatic reset_bus();
        bus_reset = 1'b1;
        @(posedge clk);
        #1;
        bus_reset = 1'b0;
        @(posedge clk);
        #1;
    endtask

    // whole bytes first, then tail_n loose bits of tail
    task automatic send(input logic [7:0] q[$], input int tail_n, input logic [7:0] tail);
        int k;
        for (int i = 0; i < q.size() * 8 + tail_n; i++)
        begin
            rx_valid = 1'b1;
            rx_bit = (i / 8 < q.size()) ? q[i / 8][i % 8] : tail[i % 8];
            k = 0;
            @(negedge clk);
            while (rx_ready !== 1'b1 && k < 300)
            begin
                k++;
                @(negedge clk);
            end
            if (k == 300)
                hang = 1'b1;
            @(posedge clk);
            #1;
        end
        rx_valid = 1'b0;
        // released line must not look like the last bit
        rx_bit = ~rx_bit;
        @(posedge clk);
        #1;
    endtask

    task automatic recv(input int nbytes, output logic [7:0] q[$]);
        logic [7:0] b;
        q = {};
        rd_slot = 1'b1;
        for (int i = 0; i < nbytes * 8; i++)
        begin
            @(posedge clk);
            #1;
            b[i % 8] = tx_bit;
            if (i % 8 == 7)
                q.push_back(b);
        end
        rd_slot = 1'b0;
        @(posedge clk);
        #1;
    endtask
endmodule

`default_nettype wire

/* testbench/scratchpad_command_slave_bench.sv */
/*
 * self-checking bench for the scratchpad command slave.
 * assumes the bus master model for all bus traffic; erase shortened to 40.
 */
`timescale 1ns/1ps
`default_nettype none

module scratchpad_command_slave_bench;
    localparam int ERASE_SIM = 40;
    logic MCLK = 1'b0;
    logic RESET = 1'b1;
    logic MEM_HOLD = 1'b0;
    logic SET_CONCEAL = 1'b0;
    logic BUS_RESET, RX_VALID, RX_BIT, RX_READY, RD_SLOT, TX_BIT, CONCEALED, PARTIAL, hang;
    logic [4:0] END_OFFSET;
    logic [7:0] FAMILY_CODE;
    logic [7:0] mem[32];
    logic [7:0] d[$];
    logic [7:0] r[$];
    logic [15:0] c;
    int n_errors = 0;
    int n_tests = 0;
    int stall_n = 0;

    always #25 MCLK = ~MCLK;

    scratchpad_command_slave #(.ERASE_CYC(ERASE_SIM)) scratchpad_command_slave_inst (
        .MCLK(MCLK), .RESET(RESET), .BUS_RESET(BUS_RESET), .RX_VALID(RX_VALID), .RX_BIT(RX_BIT),
        .RX_READY(RX_READY), .RD_SLOT(RD_SLOT), .TX_BIT(TX_BIT), .MEM_HOLD(MEM_HOLD),
        .SET_CONCEAL(SET_CONCEAL), .CONCEALED(CONCEALED), .PARTIAL(PARTIAL),
        .END_OFFSET(END_OFFSET), .FAMILY_CODE(FAMILY_CODE));

    bus_master_model bus_master_model_inst (
        .clk(MCLK), .bus_reset(BUS_RESET), .rx_valid(RX_VALID), .rx_bit(RX_BIT),
        .rx_ready(RX_READY), .rd_slot(RD_SLOT), .tx_bit(TX_BIT), .hang(hang));

    always @(negedge MCLK)
        if (RX_VALID === 1'b1 && RX_READY === 1'b0)
            stall_n++;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] crc_add(input logic [15:0] v, input logic [7:0] b);
        for (int i = 0; i < 8; i++)
            v = (v[0] ^ b[i]) ? ((v >> 1) ^ scratch_pkg::CRC_POLY_R) : (v >> 1);
        return v;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic close_out();
        $display("errors %0d, comparisons %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cmd(input logic [7:0] q[$]);
        bus_master_model_inst.reset_bus();
        bus_master_model_inst.send(q, 0, 8'h00);
    endtask

    task automatic wr(input logic [15:0] ta, input logic [7:0] q[$], input int tail_n);
        q.push_front(ta[15:8]);
        q.push_front(ta[7:0]);
        q.push_front(scratch_pkg::CMD_WRITE);
        bus_master_model_inst.reset_bus();
        bus_master_model_inst.send(q, tail_n, 8'h5c);
    endtask

    task automatic read_all(input logic [15:0] ta, input logic [7:0] es);
        logic [7:0] e[$];
        logic [15:0] v;
        e = {ta[7:0], ta[15:8], es};
        for (int i = int'(ta[4:0]); i < 32; i++)
            e.push_back(mem[i]);
        v = crc_add(scratch_pkg::CRC_INIT, scratch_pkg::CMD_READ);
        foreach (e[i])
            v = crc_add(v, e[i]);
        e.push_back(~v[7:0]);
        e.push_back(~v[15:8]);
        e.push_back(8'hff);
        cmd({scratch_pkg::CMD_READ});
        bus_master_model_inst.recv(e.size(), r);
        foreach (e[i])
            chk({8'h00, r[i]}, {8'h00, e[i]}, "read stream");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        for (int i = 0; i < 20000 && hang !== 1'b1; i++)
            @(posedge MCLK);
        n_errors++;
        $display("[FAIL] %0t bus wait ran out", $time);
        close_out();
    end

    initial
    begin
        repeat (5) @(posedge MCLK);
        #1;
        RESET = 1'b0;
        @(posedge MCLK);
        #1;
        chk({8'h00, FAMILY_CODE}, {8'h00, scratch_pkg::FAMILY_DEF}, "family");
        SET_CONCEAL = 1'b1;
        @(posedge MCLK);
        #1;
        SET_CONCEAL = 1'b0;
        chk({15'h0, CONCEALED}, 16'h0001, "conceal set");
        wr(16'h0005, {8'h77}, 0);
        chk({11'h0, END_OFFSET}, 16'h0000, "write while concealed");
        cmd({scratch_pkg::CMD_READ});
        bus_master_model_inst.recv(2, r);
        chk({r[0], r[1]}, 16'hffff, "read while concealed");
        // erase at a nonzero address: fill must ignore it
        cmd({scratch_pkg::CMD_ERASE, 8'h23, 8'h01});
        chk({15'h0, CONCEALED}, 16'h0000, "erase clears conceal");
        bus_master_model_inst.recv(1, r);
        chk({8'h00, r[0]}, 16'h00ff, "fill reads ones");
        repeat (ERASE_SIM) @(posedge MCLK);
        #1;
        bus_master_model_inst.recv(2, r);
        chk({r[0], r[1]}, 16'haaaa, "completion pattern");
        foreach (mem[i])
            mem[i] = scratch_pkg::FILL_BYTE;
        // hold the scratchpad so the fifo fills and stalls the bus
        d = {};
        for (int i = 0; i < 10; i++)
        begin
            d.push_back(8'(17 * (i + 1)));
            mem[i] = 8'(17 * (i + 1));
        end
        MEM_HOLD = 1'b1;
        fork
            wr(16'h0000, d, 0);
            begin
                repeat (120) @(posedge MCLK);
                #1;
                MEM_HOLD = 1'b0;
            end
        join
        chk({15'h0, stall_n > 0}, 16'h0001, "fifo full stalls bits");
        chk({10'h0, PARTIAL, END_OFFSET}, 16'h0009, "end offset");
        read_all(16'h0000, 8'h09);
        wr(16'h0203, {8'h33}, 0);
        chk({11'h0, END_OFFSET}, 16'h0009, "address out of range");
        wr(16'h000a, {8'h12, 8'h23, 8'h34}, 5);
        mem[10] = 8'h12;
        mem[11] = 8'h23;
        mem[12] = 8'h34;
        read_all(16'h000a, 8'h8c);
        chk({10'h0, PARTIAL, END_OFFSET}, 16'h002c, "partial byte");
        // end offset 31: sixteen slots return the plain write crc
        wr(16'h01fe, {8'hde, 8'had}, 0);
        c = scratch_pkg::CRC_INIT;
        c = crc_add(c, scratch_pkg::CMD_WRITE);
        c = crc_add(c, 8'hfe);
        c = crc_add(c, 8'h01);
        c = crc_add(c, 8'hde);
        c = crc_add(c, 8'had);
        bus_master_model_inst.recv(2, r);
        chk({r[1], r[0]}, c, "write crc");
        chk({10'h0, PARTIAL, END_OFFSET}, 16'h001f, "last offset");
        close_out();
    end
endmodule

`default_nettype wire
